// file: sab_device.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// latency
// ------------------------------------------------------------
// pins pass two flip-flops before the state register acts,
// so a pin change reaches the outputs on the third edge
// one bit time per bit: twelve for full, eight for short
// the pending flag spans exactly those bit times
// a cycle once started runs to its end unless reset

module sab_device (
    input wire logic i_clock,
    input wire logic i_rst_b,
    sab_link_if.device pins,
    input wire logic [11:0] i_analog_level,
    input wire logic i_bipolar_offset_input
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // *_s: two-stage synchronisers, only stage 1 is read
    // ce_d, rc_d: last synchronised levels, for edge detection
    // short_cyc: cycle length picked at start
    // bit_idx: bit under trial, stepping down from the msb
    // timer: cycles into the current bit time
    // sar: bits kept so far; result: last finished code
    // up, mid, lo and the enables: registered output buffers
    typedef struct packed {
        sab_pkg::sab_dev_state_e state;
        logic [1:0] ce_s;
        logic [1:0] csn_s;
        logic [1:0] rc_s;
        logic [1:0] bsel_s;
        logic [1:0] word_s;
        logic ce_d;
        logic rc_d;
        logic short_cyc;
        logic [3:0] bit_idx;
        logic [5:0] timer;
        logic [11:0] sar;
        logic [11:0] result;
        logic [3:0] up;
        logic [3:0] mid;
        logic [3:0] lo;
        logic up_oe;
        logic mid_oe;
        logic lo_oe;
    } sab_dev_s;

    sab_dev_s s;
    sab_dev_s n;
    logic [11:0] code;
    logic [11:0] trial;
    logic [3:0] last_bit;
    logic sel;
    logic start;
    logic rd;

    // ------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------
    // the comparator is modelled digitally: a code is kept when it does not exceed the level,
    // which makes the transfer monotonic with every code reachable, 12'hFFF at the top
    // bipolar input is two's complement; flipping the msb gives offset binary
    // unipolar levels are straight codes; the stand-in level
    // has no noise, so every code is hit exactly
    assign code = i_bipolar_offset_input ? {~i_analog_level[11], i_analog_level[10:0]} : i_analog_level;
    assign trial = s.sar | (12'h001 << s.bit_idx);
    assign last_bit = s.short_cyc ? sab_pkg::SHORT_LAST_BIT : sab_pkg::FULL_LAST_BIT;

    // two edges qualify a start: enable rising with convert low,
    // or convert falling with enable held high, so a held level
    // starts only once; a start during a conversion is ignored
    // reads are gated with idle so a half-built code never shows
    assign sel = ~s.csn_s[1];
    // full control: enable rises with convert level; stand-alone: convert falls with enable high
    assign start = sel && !s.rc_s[1] && s.ce_s[1] && (!s.ce_d || s.rc_d);
    assign rd = s.ce_s[1] && sel && s.rc_s[1] && (s.state == sab_pkg::SAB_D_IDLE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.ce_s = {s.ce_s[0], pins.part_enable};
        n.csn_s = {s.csn_s[0], pins.select_n};
        n.rc_s = {s.rc_s[0], pins.read_convert};
        n.bsel_s = {s.bsel_s[0], pins.byte_select_short_cycle};
        n.word_s = {s.word_s[0], pins.word_width};
        n.ce_d = s.ce_s[1];
        n.rc_d = s.rc_s[1];

        unique case (s.state)
            sab_pkg::SAB_D_IDLE: begin
                // the byte select pin is taken with the start, as the cycle length
                if (start) begin
                    n.state = sab_pkg::SAB_D_CONV;
                    n.short_cyc = s.bsel_s[1];
                    n.sar = sab_pkg::RESULT_RESET;
                    n.bit_idx = sab_pkg::MSB_BIT;
                    n.timer = 6'h00;
                end
            end
            sab_pkg::SAB_D_CONV: begin
                // further starts are not looked at here, so a running cycle finishes unless reset
                n.timer = s.timer + 6'h01;
                // decide on the last cycle of each bit time; a short
                // cycle stops after bit 4, leaving the low nibble zero
                // bit_idx stops at the last bit, so it never wraps
                if (s.timer == sab_pkg::BIT_CYC - 6'h01) begin
                    n.timer = 6'h00;
                    if (trial <= code) begin
                        n.sar = trial;
                    end
                    if (s.bit_idx == last_bit) begin
                        // short cycle leaves the low four bits zero, still left-justified
                        n.result = (trial <= code) ? trial : s.sar;
                        n.state = sab_pkg::SAB_D_IDLE;
                    end else begin
                        n.bit_idx = s.bit_idx - 4'h1;
                    end
                end
            end
        endcase

        // rebuilt every cycle from the synchronised pins, so a dropped
        // enable or select floats the bus with the same latency;
        // data is zeroed while the enables are low
        // word format drives all three nibbles together
        // output buffers, registered so the pins never glitch
        n.up = 4'h0;
        n.mid = 4'h0;
        n.lo = 4'h0;
        n.up_oe = 1'b0;
        n.mid_oe = 1'b0;
        n.lo_oe = 1'b0;
        if (rd) begin
            if (s.word_s[1]) begin
                // one 12-bit word on all three nibbles
                n.up = s.result[11:8];
                n.mid = s.result[7:4];
                n.lo = s.result[3:0];
                n.up_oe = 1'b1;
                n.mid_oe = 1'b1;
                n.lo_oe = 1'b1;
            end else if (!s.bsel_s[1]) begin
                n.up = s.result[11:8];
                n.mid = s.result[7:4];
                n.up_oe = 1'b1;
                n.mid_oe = 1'b1;
            end else begin
                n.mid = 4'h0; // leading zeros of the low byte
                n.lo = s.result[3:0];
                n.mid_oe = 1'b1;
                n.lo_oe = 1'b1; // upper nibble stays floating
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // select resets high, so no start is seen until the host
    // has driven it low through both synchroniser stages
    // result clears to zero, what a read before any conversion sees
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{state: sab_pkg::SAB_D_IDLE, csn_s: 2'h3, default: '0};
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // enables are high while a nibble is driven; the shared
    // wire is resolved outside, with no three-state drivers here
    // the flag decodes the state register, so it cannot glitch
    // data nibbles are registered, never decoded at the pin
    assign pins.conversion_pending_flag = (s.state == sab_pkg::SAB_D_CONV);
    assign pins.upper_nibble_out = s.up;
    assign pins.middle_nibble_out = s.mid;
    assign pins.lower_nibble_out = s.lo;
    assign pins.upper_oe = s.up_oe;
    assign pins.middle_oe = s.mid_oe;
    assign pins.lower_oe = s.lo_oe;
endmodule

// file: sab_host.sv
`timescale 1ns/1ps
module sab_host (
    input wire logic i_clock,
    input wire logic i_rst_b,
    sab_link_if.host pins,
    input wire logic i_conv_req,
    input wire logic i_short_cycle,
    input wire logic i_byte_format,
    output logic o_busy,
    output logic [11:0] o_result,
    output logic o_result_valid
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sab_pkg::sab_host_state_e state;
        logic [5:0] timer;
        logic byte_mode;
        logic phase;
        logic ce;
        logic cs_n;
        logic rc;
        logic bsel;
        logic word;
        logic [1:0] flag_s;
        logic [1:0][11:0] data_s;
        logic [11:0] result;
        logic valid;
    } sab_host_s;

    sab_host_s s;
    sab_host_s n;
    logic [11:0] bus_lvl;

    // undriven nibbles read as zero; the wire itself is resolved outside
    assign bus_lvl = {pins.upper_oe ? pins.upper_nibble_out : 4'h0,
                      pins.middle_oe ? pins.middle_nibble_out : 4'h0,
                      pins.lower_oe ? pins.lower_nibble_out : 4'h0};

    // ------------------------------------------------------------
    // sequencer: convert, wait for the flag, then one or two reads
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.valid = 1'b0;
        n.flag_s = {s.flag_s[0], pins.conversion_pending_flag};
        n.data_s = {s.data_s[0], bus_lvl};
        n.timer = s.timer + 6'h01;
        unique case (s.state)
            sab_pkg::SAB_H_IDLE: begin
                n.timer = 6'h00;
                n.ce = 1'b0;
                n.cs_n = 1'b1;
                n.rc = 1'b1;
                if (i_conv_req) begin
                    n.state = sab_pkg::SAB_H_CSET;
                    n.byte_mode = i_byte_format;
                    n.cs_n = 1'b0;
                    n.rc = 1'b0;
                    n.bsel = i_short_cycle;
                    n.word = ~i_byte_format;
                end
            end
            sab_pkg::SAB_H_CSET: begin
                if (s.timer == sab_pkg::SETUP_CYC - 6'h01) begin
                    n.state = sab_pkg::SAB_H_CSTB;
                    n.timer = 6'h00;
                    n.ce = 1'b1;
                end
            end
            sab_pkg::SAB_H_CSTB: begin
                if (s.timer == sab_pkg::STROBE_CYC - 6'h01) begin
                    n.state = sab_pkg::SAB_H_WRISE;
                    n.ce = 1'b0;
                end
            end
            sab_pkg::SAB_H_WRISE: begin
                if (s.flag_s[1]) begin
                    n.state = sab_pkg::SAB_H_WFALL;
                end
            end
            sab_pkg::SAB_H_WFALL: begin
                // reads only after the flag falls
                if (!s.flag_s[1]) begin
                    n.state = sab_pkg::SAB_H_RSET;
                    n.timer = 6'h00;
                    n.phase = 1'b0;
                    n.rc = 1'b1;
                    n.bsel = 1'b0;
                end
            end
            sab_pkg::SAB_H_RSET: begin
                if (s.timer == sab_pkg::SETUP_CYC - 6'h01) begin
                    n.state = sab_pkg::SAB_H_RSTB;
                    n.timer = 6'h00;
                    n.ce = 1'b1;
                end
            end
            sab_pkg::SAB_H_RSTB: begin
                // wait out the access time; the two sampling stages fall within it
                if (s.timer == sab_pkg::ACCESS_CYC - 6'h01) begin
                    n.ce = 1'b0;
                    n.timer = 6'h00;
                    if (!s.byte_mode) begin
                        n.result = s.data_s[1];
                    end else if (!s.phase) begin
                        n.result[11:4] = s.data_s[1][11:4];
                    end else begin
                        n.result[3:0] = s.data_s[1][3:0];
                    end
                    if (s.byte_mode && !s.phase) begin
                        n.state = sab_pkg::SAB_H_RSET; // upper byte first, then lower
                        n.phase = 1'b1;
                        n.bsel = 1'b1;
                    end else begin
                        n.state = sab_pkg::SAB_H_IDLE;
                        n.valid = 1'b1;
                    end
                end
            end
            default: begin
                n.state = sab_pkg::SAB_H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{state: sab_pkg::SAB_H_IDLE, cs_n: 1'b1, rc: 1'b1, default: '0};
        end else begin
            s <= n;
        end
    end

    assign pins.part_enable = s.ce;
    assign pins.select_n = s.cs_n;
    assign pins.read_convert = s.rc;
    assign pins.byte_select_short_cycle = s.bsel;
    assign pins.word_width = s.word;
    assign o_busy = (s.state != sab_pkg::SAB_H_IDLE);
    assign o_result = s.result;
    assign o_result_valid = s.valid;
endmodule

// file: sab_link_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// converter pins; three-state nibbles carried as value plus enable
// ------------------------------------------------------------
interface sab_link_if;
    logic part_enable;
    logic select_n;
    logic read_convert;
    logic byte_select_short_cycle;
    logic word_width;
    logic conversion_pending_flag;
    logic [3:0] upper_nibble_out;
    logic [3:0] middle_nibble_out;
    logic [3:0] lower_nibble_out;
    logic upper_oe;
    logic middle_oe;
    logic lower_oe;

    modport device (
        input part_enable, select_n, read_convert, byte_select_short_cycle, word_width,
        output conversion_pending_flag, upper_nibble_out, middle_nibble_out, lower_nibble_out,
        output upper_oe, middle_oe, lower_oe
    );
    modport host (
        output part_enable, select_n, read_convert, byte_select_short_cycle, word_width,
        input conversion_pending_flag, upper_nibble_out, middle_nibble_out, lower_nibble_out,
        input upper_oe, middle_oe, lower_oe
    );
endinterface

// file: sab_link_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin checks on the host/converter link
// ----------------------------------------
module sab_link_monitor (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic part_enable,
    input wire logic select_n,
    input wire logic read_convert,
    input wire logic byte_select_short_cycle,
    input wire logic word_width,
    input wire logic conversion_pending_flag,
    input wire logic [3:0] upper_nibble_out,
    input wire logic [3:0] middle_nibble_out,
    input wire logic [3:0] lower_nibble_out,
    input wire logic upper_oe,
    input wire logic middle_oe,
    input wire logic lower_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    logic rd_req;
    logic any_oe;
    logic short_r;
    logic flag_q_r;
    logic [7:0] hi_cnt_r;
    // pins reach the outputs 3 edges late (2 sync flops plus state), hence the $past depths
    assign rd_req = part_enable && !select_n && read_convert;
    assign any_oe = upper_oe || middle_oe || lower_oe;
    // length of each busy stretch; the cycle mode is latched as it starts
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hi_cnt_r <= 8'h00;
            short_r <= 1'b0;
            flag_q_r <= 1'b0;
        end else begin
            hi_cnt_r <= conversion_pending_flag ? hi_cnt_r + 8'h01 : 8'h00;
            flag_q_r <= conversion_pending_flag;
            if (conversion_pending_flag && !flag_q_r) begin
                short_r <= byte_select_short_cycle;
            end
        end
    end
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_float; !any_oe; endsequence
    sequence s_busy_run; conversion_pending_flag [*8]; endsequence
    property p_oe_cause; any_oe |-> $past(rd_req, 3); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("nibble driven without a read");
    property p_upper_fmt; upper_oe |-> $past(word_width, 3) || !$past(byte_select_short_cycle, 3); endproperty
    a_upper_fmt: assert property (p_upper_fmt) else $error("upper nibble driven in low byte");
    property p_lower_fmt; lower_oe |-> $past(word_width, 3) || $past(byte_select_short_cycle, 3); endproperty
    a_lower_fmt: assert property (p_lower_fmt) else $error("lower nibble driven in high byte");
    property p_mid_zero;
        middle_oe && !$past(word_width, 3) && $past(byte_select_short_cycle, 3) |-> middle_nibble_out == 4'h0;
    endproperty
    a_mid_zero: assert property (p_mid_zero) else $error("middle nibble not zero in low byte");
    property p_read_on;
        $past(rd_req, 3) && !conversion_pending_flag && !$past(conversion_pending_flag) |-> middle_oe;
    endproperty
    a_read_on: assert property (p_read_on) else $error("read not answered");
    property p_quiet; conversion_pending_flag |-> !any_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("data driven during conversion");
    property p_len; $fell(conversion_pending_flag) |-> hi_cnt_r == (short_r ? 8'h50 : 8'h78); endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_start;
        $rose(conversion_pending_flag) |->
            ($past(part_enable, 3) && !$past(select_n, 3) && !$past(read_convert, 3)) ##0 s_busy_run;
    endproperty
    a_start: assert property (p_start) else $error("conversion start without command");
    property p_float; $fell(part_enable) |-> ##3 s_float; endproperty
    a_float: assert property (p_float) else $error("nibbles not released");
endmodule

// file: sab_pkg.sv
package sab_pkg;
    // ------------------------------------------------------------
    // widths and result layout
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int NIB_W = 4;
    localparam logic [3:0] FULL_LAST_BIT = 4'h0;
    localparam logic [3:0] SHORT_LAST_BIT = 4'h4;
    localparam logic [3:0] MSB_BIT = 4'hB;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [11:0] UNIPOLAR_TOP = 12'hFFF;

    // ------------------------------------------------------------
    // timing, figures in ns, counts in cycles of i_clock
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int BIT_TIME_NS = 50;
    localparam int SETUP_NS = 50;
    localparam int STROBE_NS = 150;
    localparam int ACCESS_NS = 150;
    localparam int TMR_W = 6;
    localparam logic [5:0] BIT_CYC = 6'((BIT_TIME_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [5:0] SETUP_CYC = 6'((SETUP_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [5:0] STROBE_CYC = 6'((STROBE_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [5:0] ACCESS_CYC = 6'((ACCESS_NS * CLOCK_MHZ + 999) / 1000);

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SAB_D_IDLE = 1'b0,
        SAB_D_CONV = 1'b1
    } sab_dev_state_e;

    typedef enum logic [2:0] {
        SAB_H_IDLE = 3'b000,
        SAB_H_CSET = 3'b001,
        SAB_H_CSTB = 3'b010,
        SAB_H_WRISE = 3'b011,
        SAB_H_WFALL = 3'b100,
        SAB_H_RSET = 3'b101,
        SAB_H_RSTB = 3'b110
    } sab_host_state_e;
endpackage

// file: test_sar_adc_bus_interface.sv
`timescale 1ns/1ps
module test_sar_adc_bus_interface;
    logic i_clock;
    logic i_rst_b;
    logic conv_req;
    logic short_cycle;
    logic byte_format;
    logic [11:0] analog_level;
    logic bipolar;
    logic busy;
    logic [11:0] result;
    logic result_valid;
    int err_total;
    int n_tests;
    int cyc;
    int hi2;
    // rows: {short, byte, bipolar, input code, expected result}
    logic [26:0] rows [9] = '{{3'b000, 24'hABCABC}, {3'b010, 24'h5A35A3}, {3'b100, 24'hABCAB0},
        {3'b110, 24'h7FF7F0}, {3'b000, 24'hFFFFFF}, {3'b010, 24'hFFEFFE}, {3'b001, 24'h7FFFFF},
        {3'b011, 24'hFFF7FF}, {3'b001, 24'h000800}};
    sab_link_if lk ();
    sab_link_if lk2 ();
    sab_host sab_host_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .pins(lk.host), .i_conv_req(conv_req),
        .i_short_cycle(short_cycle), .i_byte_format(byte_format), .o_busy(busy), .o_result(result),
        .o_result_valid(result_valid));
    sab_device sab_device_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .pins(lk.device),
        .i_analog_level(analog_level), .i_bipolar_offset_input(bipolar));
    // second converter driven straight from the bench, so misuse can be forced on it
    sab_device sab_device_inst2 (.i_clock(i_clock), .i_rst_b(i_rst_b), .pins(lk2.device),
        .i_analog_level(12'h9C5), .i_bipolar_offset_input(1'b0));
    sab_link_monitor sab_link_monitor_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .part_enable(lk.part_enable),
        .select_n(lk.select_n), .read_convert(lk.read_convert), .byte_select_short_cycle(lk.byte_select_short_cycle),
        .word_width(lk.word_width), .conversion_pending_flag(lk.conversion_pending_flag),
        .upper_nibble_out(lk.upper_nibble_out), .middle_nibble_out(lk.middle_nibble_out),
        .lower_nibble_out(lk.lower_nibble_out), .upper_oe(lk.upper_oe), .middle_oe(lk.middle_oe),
        .lower_oe(lk.lower_oe));
    // ----------------------------------------
    // clock, hang guard, busy counter
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // generous ceiling: the whole run needs roughly 6200 cycles
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, cyc, 0);
            summarize();
        end
    end
    // busy length of the bench-driven converter, in whole cycles
    always @(negedge i_clock) begin
        if (lk2.conversion_pending_flag === 1'b1) begin
            hi2++;
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        n_tests++;
        if (got !== want) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic host_run(input logic [2:0] m, input logic [11:0] code, output logic [11:0] got);
        int k;
        @(negedge i_clock);
        {short_cycle, byte_format, bipolar} = m;
        analog_level = code;
        conv_req = 1'b1;
        @(negedge i_clock);
        conv_req = 1'b0;
        chk({11'h000, busy}, 12'h001);
        for (k = 0; k < 2000 && result_valid !== 1'b1; k++) @(negedge i_clock);
        @(negedge i_clock);
        got = result;
    endtask
    // pins of the second link: {enable, select_n, read_convert, byte select, word width}
    task automatic pins2(input logic [4:0] v);
        @(negedge i_clock);
        {lk2.part_enable, lk2.select_n, lk2.read_convert, lk2.byte_select_short_cycle, lk2.word_width} = v;
    endtask
    task automatic conv2(input logic bsel, input logic [11:0] len);
        int k;
        hi2 = 0;
        pins2({3'b000, bsel, 1'b0});
        repeat (10) @(negedge i_clock);
        pins2({3'b100, bsel, 1'b0});
        repeat (8) @(negedge i_clock);
        chk({11'h000, lk2.conversion_pending_flag}, 12'h001);
        pins2({3'b000, bsel, 1'b0});
        repeat (3) @(negedge i_clock);
        // restart, then read, while the conversion runs
        pins2({3'b100, bsel, 1'b0});
        pins2({3'b101, bsel, 1'b0});
        repeat (6) @(negedge i_clock);
        chk({9'h000, lk2.upper_oe, lk2.middle_oe, lk2.lower_oe}, 12'h000);
        pins2({3'b001, bsel, 1'b0});
        for (k = 0; k < 400 && lk2.conversion_pending_flag !== 1'b0; k++) @(negedge i_clock);
        chk(12'(hi2), len);
    endtask
    task automatic read2(input logic [4:0] v, input logic [11:0] dat, input logic [11:0] oe);
        pins2(v);
        repeat (5) @(negedge i_clock);
        chk({lk2.upper_nibble_out & {4{lk2.upper_oe}}, lk2.middle_nibble_out & {4{lk2.middle_oe}},
            lk2.lower_nibble_out & {4{lk2.lower_oe}}}, dat);
        chk({9'h000, lk2.upper_oe, lk2.middle_oe, lk2.lower_oe}, oe);
        pins2({1'b0, v[3:0]});
        repeat (5) @(negedge i_clock);
        chk({9'h000, lk2.upper_oe, lk2.middle_oe, lk2.lower_oe}, 12'h000);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i;
        int k;
        logic [11:0] got;
        logic [11:0] prev;
        {conv_req, short_cycle, byte_format, bipolar, analog_level} = 16'h0000;
        {lk2.part_enable, lk2.select_n, lk2.read_convert, lk2.byte_select_short_cycle, lk2.word_width} = 5'b01000;
        i_rst_b = 1'b0;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        chk({5'h00, busy, result_valid, lk.conversion_pending_flag, lk.upper_oe, lk.middle_oe, lk.lower_oe,
            lk.select_n}, 12'h001);
        chk(result, 12'h000);
        i_rst_b = 1'b1;
        $display("reset test done");
        for (i = 0; i < 9; i++) begin
            host_run(rows[i][26:24], rows[i][23:12], got);
            chk(got, rows[i][11:0]);
            $display("row %0d done", i);
        end
        prev = 12'h000;
        for (i = 1; i < 16; i++) begin
            host_run(3'b010, 12'(i * 273), got);
            chk(got, 12'(i * 273));
            chk({11'h000, got > prev}, 12'h001);
            prev = got;
        end
        $display("sweep test done");
        // a request while busy is dropped, so exactly one answer follows
        fork
            host_run(3'b100, 12'h3C3, got);
            begin
                repeat (60) @(negedge i_clock);
                conv_req = 1'b1;
                @(negedge i_clock);
                conv_req = 1'b0;
            end
        join
        chk(got, 12'h3C0);
        k = 0;
        repeat (400) begin
            @(negedge i_clock);
            k += (result_valid === 1'b1);
        end
        chk(12'(k), 12'h000);
        $display("busy request test done");
        // reset in mid-conversion drops both ends to idle at once
        conv_req = 1'b1;
        @(negedge i_clock);
        conv_req = 1'b0;
        repeat (60) @(negedge i_clock);
        chk({11'h000, lk.conversion_pending_flag}, 12'h001);
        i_rst_b = 1'b0;
        #1;
        chk({9'h000, busy, lk.conversion_pending_flag, lk.select_n}, 12'h001);
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (2) @(negedge i_clock);
        chk({10'h000, busy, lk.conversion_pending_flag}, 12'h000);
        host_run(3'b000, 12'h5A5, got);
        chk(got, 12'h5A5);
        $display("mid-run reset test done");
        conv2(1'b0, 12'h078);
        read2(5'b10100, 12'h9C0, 12'h006);
        read2(5'b10110, 12'h005, 12'h003);
        read2(5'b10101, 12'h9C5, 12'h007);
        read2(5'b11101, 12'h000, 12'h000);
        read2(5'b00101, 12'h000, 12'h000);
        conv2(1'b1, 12'h050);
        read2(5'b10101, 12'h9C0, 12'h007);
        // stand-alone: enable held high, falling read/convert starts a conversion
        pins2(5'b10100);
        pins2(5'b10000);
        repeat (8) @(negedge i_clock);
        chk({11'h000, lk2.conversion_pending_flag}, 12'h001);
        for (k = 0; k < 400 && lk2.conversion_pending_flag !== 1'b0; k++) @(negedge i_clock);
        $display("direct pin test done");
        summarize();
    end
endmodule
